/* port_pad_defs.svh */
`ifndef PORT_PAD_DEFS_SVH
`define PORT_PAD_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_SPEED        8'h08
`define OFS_PULL         8'h0c
`define OFS_INPUT        8'h10

// ==========================================================
// Reset values
`define RST_SPEED_FIRST  32'h0c00_0000
`define RST_SPEED_OTHER  32'h0000_0000
`define RST_PULL_FIRST   32'h2400_0000
`define RST_PULL_OTHER   32'h0000_0000
`define INPUT_UPPER_ZERO 16'h0000

// ==========================================================
// Field layout
`define FIELD_W          2
`define PIN_COUNT        16
`define INPUT_LSB        0
`define INPUT_MSB        15

// ==========================================================
// Field codes
`define SPEED_MID_CODE   2'h1
`define SPEED_FAST_CODE  2'h3
`define PULL_NONE_CODE   2'h0
`define PULL_UP_CODE     2'h1
`define PULL_DOWN_CODE   2'h2

`endif

/* port_pad_pkg.sv */
package port_pad_pkg;

  // ========================================================
  // Drive class selected by a pin speed field
  typedef enum logic [1:0] {
    DRIVE_SLOW,
    DRIVE_MID,
    DRIVE_FAST
  } drive_class_e;

  // Per-pin mode from the neighbouring mode register
  typedef enum logic [1:0] {
    MODE_INPUT,
    MODE_OUTPUT,
    MODE_ALT,
    MODE_ANALOG
  } pin_mode_e;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;    // Byte address
    logic [31:0] wdata;   // Write data
    logic [3:0]  be;      // Byte lanes of a write
    logic        wr;      // Write strobe
    logic        rd;      // Read strobe
  } bus_req_s;

  // Decoded pad controls, one bit per pin
  typedef struct packed {
    logic [15:0] drive_slow;
    logic [15:0] drive_mid;
    logic [15:0] drive_fast;
    logic [15:0] pull_up;
    logic [15:0] pull_down;
  } pad_ctrl_s;

endpackage : port_pad_pkg

/* port_pad_config.sv */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`include "port_pad_defs.svh"

// Functional notes
// - Byte, half and word writes update addressed lanes
// - Two-bit speed field per pin, software owned
// - Speed x0 slow, 01 middle, 11 fast
// - Speed reset value depends on port
// - Two-bit pull field per pin, software owned
// - Pull 00 none, 01 up, 10 down
// - Pull reset value depends on port
// - Input bits show sampled pin levels, read-only
// - Input upper half reads zero after reset
// - Mode field qualifies speed and pull
module port_pad_config
  import port_pad_pkg::*;
#(
  parameter bit          FIRST_PORT = 1'b1,        // Selects first-port reset values
  parameter int unsigned PINS       = `PIN_COUNT    // Pins in the port
) (
  input  wire logic              ref_clk,          // Bus clock
  input  wire logic              rst,              // Synchronous reset, active high
  input  wire bus_req_s          bus_req,          // Register request
  output logic      [31:0]       rd_data,          // Read data, cycle after rd
  input  wire logic [2*PINS-1:0] pin_mode_field,   // Mode fields, same clock
  input  wire logic [PINS-1:0]   pin_in,           // Raw pad levels, asynchronous
  output pad_ctrl_s              pad_ctrl          // Registered pad controls
);

  // ========================================================
  // Constants
  localparam logic [31:0] SPEED_RST = FIRST_PORT ? `RST_SPEED_FIRST : `RST_SPEED_OTHER;
  localparam logic [31:0] PULL_RST  = FIRST_PORT ? `RST_PULL_FIRST  : `RST_PULL_OTHER;

  // ========================================================
  // Storage
  logic [31:0]     pin_drive_speed;   // Speed fields, two bits per pin
  logic [31:0]     pin_pull_select;   // Pull fields, two bits per pin
  logic [PINS-1:0] sync_first;        // First synchroniser stage
  logic [PINS-1:0] pin_input_level;   // Second stage, register contents
  pad_ctrl_s       next_pad_ctrl;     // Decoded controls before the flop

  // ========================================================
  // Functions

  // Merge write data into a register, lane by lane
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_lanes

  // Decode one speed field into a drive class
  function automatic drive_class_e decode_speed(input logic [1:0] f);
    drive_class_e d;
    d = DRIVE_SLOW;
    if (f == `SPEED_FAST_CODE) begin
      d = DRIVE_FAST;
    end else if (f == `SPEED_MID_CODE) begin
      d = DRIVE_MID;
    end
    return d;
  endfunction : decode_speed

  // ========================================================
  // Address decode
  // Addresses compare whole; a near miss falls to the default read
  wire logic wr_speed = bus_req.wr && (bus_req.addr == `OFS_SPEED);
  wire logic wr_pull  = bus_req.wr && (bus_req.addr == `OFS_PULL);

  // ========================================================
  // Speed register: only software changes it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_drive_speed <= SPEED_RST;
    end else if (wr_speed) begin
      // Lanes not enabled keep their value
      pin_drive_speed <= merge_lanes(pin_drive_speed, bus_req.wdata, bus_req.be);
    end
  end

  // ========================================================
  // Pull register: only software changes it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_pull_select <= PULL_RST;
    end else if (wr_pull) begin
      // Code 11 is stored as written; decode treats it as no pull
      pin_pull_select <= merge_lanes(pin_pull_select, bus_req.wdata, bus_req.be);
    end
  end

  // ========================================================
  // Pin synchroniser: pads change with no regard for ref_clk
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_first      <= '0;
      pin_input_level <= '0;
    end else begin
      sync_first      <= pin_in;
      pin_input_level <= sync_first;
    end
  end

  // ========================================================
  // Read path: one register stage, unmapped reads return zero
  // Narrow reads of the input register are not decoded apart;
  // software is expected to read it by word.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= '0;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `OFS_SPEED: begin
          rd_data <= pin_drive_speed;
        end
        `OFS_PULL: begin
          rd_data <= pin_pull_select;
        end
        `OFS_INPUT: begin
          // Upper half reserved; writes to this offset are dropped
          rd_data <= {`INPUT_UPPER_ZERO, 16'(pin_input_level)};
        end
        default: begin
          rd_data <= '0;
        end
      endcase
    end
  end

  // ========================================================
  // Pad control decode: mode gates speed and pull
  // Decode is combinational; the flop below is the only path to the pads
  always_comb begin
    next_pad_ctrl = '0;
    for (int p = 0; p < PINS; p++) begin
      // Drive class matters only while the pin drives
      if (pin_mode_field[2*p +: 2] == MODE_OUTPUT ||
          pin_mode_field[2*p +: 2] == MODE_ALT) begin
        case (decode_speed(pin_drive_speed[2*p +: 2]))
          DRIVE_FAST: begin
            next_pad_ctrl.drive_fast[p] = 1'b1;
          end
          DRIVE_MID: begin
            next_pad_ctrl.drive_mid[p] = 1'b1;
          end
          default: begin
            next_pad_ctrl.drive_slow[p] = 1'b1;
          end
        endcase
      end
      // Analog pads must not see a resistor on the signal
      if (pin_mode_field[2*p +: 2] != MODE_ANALOG) begin
        next_pad_ctrl.pull_up[p]   =
          (pin_pull_select[2*p +: 2] == `PULL_UP_CODE);
        next_pad_ctrl.pull_down[p] =
          (pin_pull_select[2*p +: 2] == `PULL_DOWN_CODE);
      end
    end
  end

  // ========================================================
  // Pad control flop: keeps glitches off the pad drivers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pad_ctrl <= '0;
    end else begin
      pad_ctrl <= next_pad_ctrl;
    end
  end

  // ========================================================
  // Checks
  // Pin-level checks watch pin 0, 1 or 15; the decode is one loop,
  // so a slip there shows on any pin that random stimulus reaches.

  // Word write lands whole, byte write touches only its lane
  speed_lanes_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_speed |=> pin_drive_speed ==
      merge_lanes($past(pin_drive_speed), $past(bus_req.wdata), $past(bus_req.be)))
    else $error("speed register lanes wrong after write");

  // Pull register holds when nothing addresses it
  pull_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !wr_pull |=> $stable(pin_pull_select))
    else $error("pull register changed without a write");

  // Speed register holds when nothing addresses it
  speed_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !wr_speed |=> $stable(pin_drive_speed))
    else $error("speed register changed without a write");

  // Reset loads the port reset values
  reset_values_a: assert property (
    @(posedge ref_clk)
    rst |=> (pin_drive_speed == SPEED_RST) && (pin_pull_select == PULL_RST))
    else $error("reset values wrong");

  // Pin 15 fast code in output mode drives fast one edge later
  fast_decode_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (pin_drive_speed[31:30] == `SPEED_FAST_CODE &&
     pin_mode_field[31:30] == MODE_OUTPUT)
    |=> pad_ctrl.drive_fast[15] && !pad_ctrl.drive_slow[15])
    else $error("fast speed not decoded");

  // Pin 0 pull-up code gives pull-up unless analog
  pull_decode_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (pin_pull_select[1:0] == `PULL_UP_CODE &&
     pin_mode_field[1:0] != MODE_ANALOG)
    |=> pad_ctrl.pull_up[0] && !pad_ctrl.pull_down[0])
    else $error("pull-up not decoded");

  // Analog pins get neither pulls nor drive
  mode_gate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (pin_mode_field[1:0] == MODE_ANALOG) |=>
      !pad_ctrl.pull_up[0] && !pad_ctrl.pull_down[0] && !pad_ctrl.drive_slow[0] &&
      !pad_ctrl.drive_mid[0] && !pad_ctrl.drive_fast[0])
    else $error("analog pin not isolated");

  // Pin level reaches the register after exactly two edges
  pin_sync_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !rst ##1 !rst ##1 1'b1 |-> pin_input_level == $past(pin_in, 2))
    else $error("synchroniser latency wrong");

  // Input read shows zero upper half and the sampled levels
  input_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (bus_req.rd && bus_req.addr == `OFS_INPUT) |=>
      rd_data == {`INPUT_UPPER_ZERO, $past(16'(pin_input_level))})
    else $error("input register read wrong");

  // Input upper half stays zero even after a write there
  input_upper_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (bus_req.rd && bus_req.addr == `OFS_INPUT) |=> rd_data[31:16] == 16'h0000)
    else $error("reserved input bits not zero");

  // Pull register write lands lane by lane like the speed register
  pull_lanes_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_pull |=> pin_pull_select ==
      merge_lanes($past(pin_pull_select), $past(bus_req.wdata), $past(bus_req.be)))
    else $error("pull register lanes wrong after write");

  // Speed read returns the register as it stood at the strobe
  speed_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (bus_req.rd && bus_req.addr == `OFS_SPEED) |=> rd_data == $past(pin_drive_speed))
    else $error("speed register read wrong");

  // Pull read returns the register as it stood at the strobe
  pull_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (bus_req.rd && bus_req.addr == `OFS_PULL) |=> rd_data == $past(pin_pull_select))
    else $error("pull register read wrong");

  // Reads outside the three offsets return zero
  unmapped_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (bus_req.rd && bus_req.addr != `OFS_SPEED && bus_req.addr != `OFS_PULL &&
     bus_req.addr != `OFS_INPUT) |=> rd_data == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Read data stands until the next read answer
  rd_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !bus_req.rd |=> $stable(rd_data))
    else $error("read data changed without a read");

  // Pin 0 middle code in a driving mode selects the middle drive only
  mid_decode_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (pin_drive_speed[1:0] == `SPEED_MID_CODE &&
     (pin_mode_field[1:0] == MODE_OUTPUT || pin_mode_field[1:0] == MODE_ALT))
    |=> pad_ctrl.drive_mid[0] && !pad_ctrl.drive_slow[0] && !pad_ctrl.drive_fast[0])
    else $error("middle speed not decoded");

  // Pin 0 code with bit 0 clear selects the slow drive, 10 included
  slow_decode_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (!pin_drive_speed[0] &&
     (pin_mode_field[1:0] == MODE_OUTPUT || pin_mode_field[1:0] == MODE_ALT))
    |=> pad_ctrl.drive_slow[0] && !pad_ctrl.drive_mid[0] && !pad_ctrl.drive_fast[0])
    else $error("slow speed not decoded");

  // Input pins never get any drive
  input_nodrive_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (pin_mode_field[1:0] == MODE_INPUT) |=>
      !pad_ctrl.drive_slow[0] && !pad_ctrl.drive_mid[0] && !pad_ctrl.drive_fast[0])
    else $error("input pin driven");

  // Pin 1 pull-down code gives pull-down unless analog
  pull_down_decode_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (pin_pull_select[3:2] == `PULL_DOWN_CODE &&
     pin_mode_field[3:2] != MODE_ANALOG)
    |=> pad_ctrl.pull_down[1] && !pad_ctrl.pull_up[1])
    else $error("pull-down not decoded");

  // Floating code leaves pin 0 with no resistor
  pull_none_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (pin_pull_select[1:0] == `PULL_NONE_CODE) |=>
      !pad_ctrl.pull_up[0] && !pad_ctrl.pull_down[0])
    else $error("floating pin has a pull");

  // At most one drive class per pin, never both pulls at once
  pad_excl_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ((pad_ctrl.drive_slow & pad_ctrl.drive_mid) == 16'h0000) &&
    ((pad_ctrl.drive_slow & pad_ctrl.drive_fast) == 16'h0000) &&
    ((pad_ctrl.drive_mid & pad_ctrl.drive_fast) == 16'h0000) &&
    ((pad_ctrl.pull_up & pad_ctrl.pull_down) == 16'h0000))
    else $error("pad controls in conflict");

  // First synchroniser stage follows the pad one edge later
  sync_stage_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !rst |=> sync_first == $past(pin_in))
    else $error("first synchroniser stage wrong");

  // Reset clears read data and every pad control
  reset_outputs_a: assert property (
    @(posedge ref_clk)
    rst |=> (rd_data == 32'h0000_0000) && (pad_ctrl == '0))
    else $error("outputs not cleared by reset");

endmodule : port_pad_config

/* port_pad_config_tb.sv */
`timescale 1ns/10ps
`include "port_pad_defs.svh"

// =====================================================================
// Compare helper: counts every check, reports and counts each mismatch
`define CHK(what, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("unexpected %s exp %h got %h", what, exp, got); \
    end \
  end

module port_pad_config_tb
  import port_pad_pkg::*;
;
  // =====================================================================
  // Stimulus, observed outputs and reference model state
  logic        ref_clk;         // Bus clock, 5 ns period
  logic        rst;             // Synchronous reset
  bus_req_s    bus_req;         // Register request
  logic [31:0] rd_data;         // Read data from the block
  logic [31:0] pin_mode_field;  // Mode fields driven in place of the mode register
  logic [15:0] pin_in;          // Raw pad levels
  pad_ctrl_s   pad_ctrl;        // Decoded pad controls
  logic [31:0] m_speed;         // Model of the speed register
  logic [31:0] m_pull;          // Model of the pull register
  logic [15:0] old_pins;        // Pin levels before a change
  logic [3:0]  be_tab [7];      // Legal byte, half and word lane patterns
  int          failures;        // Mismatch count
  int          n_tests;         // Comparison count

  port_pad_config #(.FIRST_PORT(1'b1), .PINS(16)) u_port_pad_config (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .bus_req        (bus_req),
    .rd_data        (rd_data),
    .pin_mode_field (pin_mode_field),
    .pin_in         (pin_in),
    .pad_ctrl       (pad_ctrl)
  );

  // =====================================================================
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // =====================================================================
  // Bus tasks; each waits an edge first so strobes never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] lanes);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, be: lanes, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    // Model only touches the addressed lanes of the two writable registers
    for (int b = 0; b < 4; b++) begin
      if (lanes[b] && a == `OFS_SPEED) m_speed[8*b+:8] = d[8*b+:8];
      if (lanes[b] && a == `OFS_PULL) m_pull[8*b+:8] = d[8*b+:8];
    end
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 32'h0, be: 4'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    // Read data is valid from this cycle and holds until the next read answer
    #1;
    `CHK(what, exp, rd_data)
  endtask : rd_chk

  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    m_speed = 32'h0c00_0000;
    m_pull  = 32'h2400_0000;
  endtask : do_reset

  // Expected pad controls: drive only in output or alternate, no pull in analog
  function automatic pad_ctrl_s exp_pad();
    pad_ctrl_s  e;
    logic [1:0] m;
    logic [1:0] s;
    logic [1:0] p;
    e = '0;
    for (int y = 0; y < 16; y++) begin
      m = pin_mode_field[2*y+:2];
      s = m_speed[2*y+:2];
      p = m_pull[2*y+:2];
      if (m == 2'h1 || m == 2'h2) begin
        e.drive_slow[y] = ~s[0];
        e.drive_mid[y]  = (s == 2'h1);
        e.drive_fast[y] = (s == 2'h3);
      end
      e.pull_up[y]   = (p == 2'h1) && (m != 2'h3);
      e.pull_down[y] = (p == 2'h2) && (m != 2'h3);
    end
    return e;
  endfunction : exp_pad

  task automatic wrap_up();
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // =====================================================================
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end

  // =====================================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    rst            = 1'b1;
    bus_req        = '0;
    pin_mode_field = 32'h0;
    pin_in         = 16'h0;
    failures       = 0;
    n_tests        = 0;
    be_tab         = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
    void'($urandom(32'h0baf));
    do_reset();
    rd_chk(`OFS_SPEED, 32'h0c00_0000, "speed after reset");
    rd_chk(`OFS_PULL, 32'h2400_0000, "pull after reset");
    rd_chk(`OFS_INPUT, 32'h0, "input after reset");
    // Random modes, lanes and codes; pins held steady through each pass
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      pin_mode_field <= $urandom;
      pin_in         <= 16'($urandom);
      wr(`OFS_SPEED, $urandom, be_tab[$urandom_range(6)]);
      r = $urandom;
      // Reserved pull code 11 is never written
      wr(`OFS_PULL, r & ~((r & 32'h5555_5555) << 1), be_tab[$urandom_range(6)]);
      rd_chk(`OFS_SPEED, m_speed, "speed register");
      rd_chk(`OFS_PULL, m_pull, "pull register");
      rd_chk(`OFS_INPUT, {16'h0, pin_in}, "input level");
      `CHK("pad controls", exp_pad(), pad_ctrl)
    end
    // Input register and unmapped space ignore writes
    wr(`OFS_INPUT, 32'hffff_ffff, 4'hf);
    wr(8'h04, 32'hffff_ffff, 4'hf);
    rd_chk(`OFS_INPUT, {16'h0, pin_in}, "input after write");
    rd_chk(8'h04, 32'h0, "unmapped read");
    rd_chk(`OFS_SPEED, m_speed, "speed after stray writes");
    // A pin change must not be seen before two synchroniser stages
    old_pins = pin_in;
    @(posedge ref_clk);
    pin_in <= ~old_pins;
    rd_chk(`OFS_INPUT, {16'h0, old_pins}, "input one stage");
    rd_chk(`OFS_INPUT, {16'h0, ~old_pins}, "input two stages");
    // Reset in mid-run restores the port values
    do_reset();
    rd_chk(`OFS_SPEED, 32'h0c00_0000, "speed second reset");
    rd_chk(`OFS_PULL, 32'h2400_0000, "pull second reset");
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("pads second reset", exp_pad(), pad_ctrl)
    wrap_up();
  end

endmodule : port_pad_config_tb
